// ==== hdl/mdc_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// - wrap on: burst read jumps from 0x06 to 0x33 when fast read is off
// - wrap on with fast read: burst read jumps from 0x05 to 0x33
// - tracking disable bit: 0 tracks extremes, 1 stops tracking
// - tracking on: each ODR cycle end updates per-axis max and min
// - stop-on-threshold bit set: threshold event halts tracking; clear: no effect
// - writing clear bit loads minima with 0x7FFF and maxima with 0x8000
// - clear bit self-clears after the reload; zero means nothing pending
// - interval 0b00: degauss at the start of every ODR cycle
// - interval 0b01: degauss every 16 cycles; 0b10: every 512 cycles
// - interval 0b11: degauss only on wake-up or one-shot request
// - autocal on: offsets load (max+min)/2 at each ODR cycle end
// - one-shot request degausses once, then the bit is cleared by hardware
// - hybrid mode halves the magnetic ODR rate

// ==========================================================================
// magnetic extremes tracking and degauss control
// ==========================================================================
module mdc_ctrl
  import mdc_pkg::*;
(
  input  wire logic        SYS_CLK,          // system clock, 50 MHz
  input  wire logic        NRST,             // async reset, active low
  input  wire logic        LINK_CLK,         // sensor link clock
  input  wire logic        LINK_ODR_END,     // link: ODR cycle end strobe
  input  wire logic [15:0] LINK_SAMP_X,      // link: x sample
  input  wire logic [15:0] LINK_SAMP_Y,      // link: y sample
  input  wire logic [15:0] LINK_SAMP_Z,      // link: z sample
  input  wire logic        LINK_THS_EVT,     // link: threshold event
  input  wire logic [7:0]  REG_ADDR,         // register address
  input  wire logic        REG_WR,           // write strobe
  input  wire logic        REG_RD,           // read strobe
  input  wire logic [7:0]  REG_WDATA,        // write data
  input  wire logic        FAST_READ,        // truncated burst read option
  input  wire logic [1:0]  SENSOR_SEL,       // sensor select code
  input  wire logic        AUTOCAL_EN,       // hard-iron autocal enable
  input  wire logic        ONESHOT_DEGAUSS,  // one-shot degauss bit
  input  wire logic        ACTIVE_MODE,      // 1 = active, 0 = standby
  output logic      [7:0]  REG_RDATA,        // read data
  output logic      [7:0]  BURST_NEXT_ADDR,  // next burst address
  output logic      [47:0] MAG_MAX,          // {z,y,x} maxima
  output logic      [47:0] MAG_MIN,          // {z,y,x} minima
  output logic      [47:0] MAG_OFFSET,       // {z,y,x} offsets
  output logic             DEGAUSS,          // sensor reset pulse
  output logic             ONESHOT_CLEAR     // clears one-shot bit
);

  // ========================================================================
  // helpers
  // ========================================================================
  function automatic logic [15:0] smax(input logic [15:0] a, input logic [15:0] b);
    smax = ($signed(a) > $signed(b)) ? a : b;
  endfunction

  function automatic logic [15:0] smin(input logic [15:0] a, input logic [15:0] b);
    smin = ($signed(a) < $signed(b)) ? a : b;
  endfunction

  // half of the signed sum, kept at 17 bits so no overflow
  function automatic logic [15:0] mid(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s   = {a[15], a} + {b[15], b};
    mid = s[16:1];
  endfunction

  // ========================================================================
  // link capture and crossing
  // ========================================================================
  logic [47:0] link_held;
  logic        link_ths;
  logic        link_tog;

  mdc_sample_link u_link (
    .link_clk (LINK_CLK),
    .nrst     (NRST),
    .odr_end  (LINK_ODR_END),
    .samp_x   (LINK_SAMP_X),
    .samp_y   (LINK_SAMP_Y),
    .samp_z   (LINK_SAMP_Z),
    .ths_evt  (LINK_THS_EVT),
    .held_ff  (link_held),
    .ths_ff   (link_ths),
    .tog_ff   (link_tog)
  );

  logic tog_s1_ff;
  logic tog_s2_ff;
  logic tog_s3_ff;
  logic tog_acc_ff;
  logic frame_evt;

  // three-stage sync; first stage feeds only the second
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      tog_s1_ff  <= 1'b0;
      tog_s2_ff  <= 1'b0;
      tog_s3_ff  <= 1'b0;
      tog_acc_ff <= 1'b0;
    end else begin
      tog_s1_ff  <= link_tog;
      tog_s2_ff  <= tog_s1_ff;
      tog_s3_ff  <= tog_s2_ff;
      tog_acc_ff <= (tog_s2_ff == tog_s3_ff) ? tog_s2_ff : tog_acc_ff;
    end
  end

  // frame data is frozen on the link side long before the toggle lands
  assign frame_evt = (tog_s2_ff == tog_s3_ff) && (tog_s2_ff != tog_acc_ff);

  // ========================================================================
  // register, tracking and degauss state
  // ========================================================================
  logic [7:0]  ctrl_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  naddr_ff;
  logic [47:0] max_ff;
  logic [47:0] min_ff;
  logic [47:0] off_ff;
  logic        ths_stop_ff;
  logic        half_ff;
  logic [8:0]  deg_cnt_ff;
  logic        deg_ff;
  logic        os_busy_ff;
  logic        os_clr_ff;
  logic        active_ff;

  logic [7:0]  nxt_ctrl;
  logic [7:0]  nxt_rdata;
  logic [7:0]  nxt_naddr;
  logic [47:0] nxt_max;
  logic [47:0] nxt_min;
  logic [47:0] nxt_off;
  logic        nxt_ths_stop;
  logic        nxt_half;
  logic [8:0]  nxt_deg_cnt;
  logic        nxt_deg;
  logic        nxt_os_busy;
  logic        nxt_os_clr;
  logic        mag_tick;
  logic        tracking;
  logic        wr_hit;
  logic        wake;
  logic [9:0]  period;

  assign wr_hit = REG_WR && (REG_ADDR == ADDR_MAG_CTRL_TWO);
  assign wake   = ACTIVE_MODE && !active_ff;

  // next-state for everything on the system clock except the toggle sync and active_ff
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_rdata    = rdata_ff;
    nxt_naddr    = naddr_ff;
    nxt_max      = max_ff;
    nxt_min      = min_ff;
    nxt_off      = off_ff;
    nxt_ths_stop = ths_stop_ff;
    nxt_half     = half_ff;
    nxt_deg_cnt  = deg_cnt_ff;
    nxt_deg      = 1'b0;
    nxt_os_busy  = os_busy_ff;
    nxt_os_clr   = 1'b0;
    mag_tick     = 1'b0;
    period       = DEG_PER_16;

    // register read and burst address
    if (REG_RD) begin
      nxt_rdata = (REG_ADDR == ADDR_MAG_CTRL_TWO) ? ctrl_ff : 8'h00;
      nxt_naddr = REG_ADDR + 8'h01;
      if (ctrl_ff[BIT_HYB_WRAP] && !FAST_READ && REG_ADDR == ADDR_ACC_Z_LSB) begin
        nxt_naddr = ADDR_MAG_X_MSB;
      end
      if (ctrl_ff[BIT_HYB_WRAP] && FAST_READ && REG_ADDR == ADDR_ACC_Z_MSB) begin
        nxt_naddr = ADDR_MAG_X_MSB;
      end
    end

    // magnetic ODR tick; hybrid passes every second frame
    if (frame_evt && SENSOR_SEL != SEL_ACC_ONLY && ACTIVE_MODE) begin
      if (SENSOR_SEL == SEL_HYBRID) begin
        nxt_half = ~half_ff;
        mag_tick = half_ff;
      end else begin
        mag_tick = 1'b1;
      end
    end

    // threshold stop latches until the extremes are cleared
    if (mag_tick && link_ths && ctrl_ff[BIT_TRK_DIS_THS]) begin
      nxt_ths_stop = 1'b1;
    end
    tracking = !ctrl_ff[BIT_TRK_DIS] && !ths_stop_ff;

    // extremes update, then the reload takes precedence
    if (mag_tick && tracking) begin
      for (int a = 0; a < 3; a++) begin
        nxt_max[a*16 +: 16] = smax(max_ff[a*16 +: 16], link_held[a*16 +: 16]);
        nxt_min[a*16 +: 16] = smin(min_ff[a*16 +: 16], link_held[a*16 +: 16]);
      end
    end
    if (ctrl_ff[BIT_TRK_CLR]) begin
      nxt_max          = {3{MAX_RST_VAL}};
      nxt_min          = {3{MIN_RST_VAL}};
      nxt_ths_stop     = 1'b0;
      nxt_ctrl[BIT_TRK_CLR] = 1'b0;
    end
    if (mag_tick && AUTOCAL_EN) begin
      for (int a = 0; a < 3; a++) begin
        nxt_off[a*16 +: 16] = mid(nxt_max[a*16 +: 16], nxt_min[a*16 +: 16]);
      end
    end

    // software write; its set of the clear bit beats the hardware clear
    if (wr_hit) begin
      nxt_ctrl = REG_WDATA;
    end

    // periodic degauss at the start of a cycle
    case (ctrl_ff[BIT_DEG_HI:BIT_DEG_LO])
      DEG_EVERY: period = 10'h001;
      DEG_16:    period = DEG_PER_16;
      DEG_512:   period = DEG_PER_512;
      DEG_OFF:   period = 10'h000;
      default:   period = 10'h000;
    endcase
    if (wake) begin
      nxt_deg     = 1'b1;
      nxt_deg_cnt = 9'h001;
      nxt_half    = 1'b0;
    end else if (mag_tick && period != 10'h000) begin
      if ({1'b0, deg_cnt_ff} >= period - 10'h001) begin
        nxt_deg     = 1'b1;
        nxt_deg_cnt = 9'h000;
      end else begin
        nxt_deg_cnt = deg_cnt_ff + 9'h001;
      end
    end

    // one-shot degauss, cleared once the pulse has gone out
    if (ONESHOT_DEGAUSS && !os_busy_ff) begin
      nxt_deg     = 1'b1;
      nxt_os_busy = 1'b1;
    end else if (os_busy_ff && !os_clr_ff && !deg_ff) begin
      nxt_os_clr  = 1'b0;
    end
    if (os_busy_ff && deg_ff) begin
      nxt_os_clr = 1'b1;
    end
    if (os_clr_ff) begin
      nxt_os_busy = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_ff     <= CTRL_TWO_RST_VAL;
      rdata_ff    <= 8'h00;
      naddr_ff    <= 8'h00;
      max_ff      <= {3{MAX_RST_VAL}};
      min_ff      <= {3{MIN_RST_VAL}};
      off_ff      <= 48'h000000000000;
      ths_stop_ff <= 1'b0;
      half_ff     <= 1'b0;
      deg_cnt_ff  <= 9'h000;
      deg_ff      <= 1'b0;
      os_busy_ff  <= 1'b0;
      os_clr_ff   <= 1'b0;
      active_ff   <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      rdata_ff    <= nxt_rdata;
      naddr_ff    <= nxt_naddr;
      max_ff      <= nxt_max;
      min_ff      <= nxt_min;
      off_ff      <= nxt_off;
      ths_stop_ff <= nxt_ths_stop;
      half_ff     <= nxt_half;
      deg_cnt_ff  <= nxt_deg_cnt;
      deg_ff      <= nxt_deg;
      os_busy_ff  <= nxt_os_busy;
      os_clr_ff   <= nxt_os_clr;
      active_ff   <= ACTIVE_MODE;
    end
  end

  // outputs straight from flops
  assign REG_RDATA       = rdata_ff;
  assign BURST_NEXT_ADDR = naddr_ff;
  assign MAG_MAX         = max_ff;
  assign MAG_MIN         = min_ff;
  assign MAG_OFFSET      = off_ff;
  assign DEGAUSS         = deg_ff;
  assign ONESHOT_CLEAR   = os_clr_ff;

endmodule

// ==== hdl/mdc_pkg.sv ====
// ==========================================================================
// shared constants for the magnetic extremes and degauss control block
// ==========================================================================
package mdc_pkg;

  // ========================================================================
  // register map
  // ========================================================================
  localparam logic [7:0] ADDR_MAG_CTRL_TWO = 8'h5C;
  localparam logic [7:0] CTRL_TWO_RST_VAL  = 8'h00;

  // field positions inside mag_control_two
  localparam int BIT_HYB_WRAP    = 5;
  localparam int BIT_TRK_DIS     = 4;
  localparam int BIT_TRK_DIS_THS = 3;
  localparam int BIT_TRK_CLR     = 2;
  localparam int BIT_DEG_HI      = 1;
  localparam int BIT_DEG_LO      = 0;

  // ========================================================================
  // burst-read wrap addresses
  // ========================================================================
  localparam logic [7:0] ADDR_ACC_Z_LSB = 8'h06;
  localparam logic [7:0] ADDR_ACC_Z_MSB = 8'h05;
  localparam logic [7:0] ADDR_MAG_X_MSB = 8'h33;

  // ========================================================================
  // extremes reload values
  // ========================================================================
  localparam logic [15:0] MIN_RST_VAL = 16'h7FFF;
  localparam logic [15:0] MAX_RST_VAL = 16'h8000;

  // ========================================================================
  // degauss interval codes and periods (in magnetic ODR cycles)
  // ========================================================================
  localparam logic [1:0] DEG_EVERY  = 2'h0;
  localparam logic [1:0] DEG_16     = 2'h1;
  localparam logic [1:0] DEG_512    = 2'h2;
  localparam logic [1:0] DEG_OFF    = 2'h3;
  // ten bits: a 512-cycle period does not fit in nine
  localparam logic [9:0] DEG_PER_16  = 10'h010;
  localparam logic [9:0] DEG_PER_512 = 10'h200;

  // ========================================================================
  // sensor select codes
  // ========================================================================
  localparam logic [1:0] SEL_ACC_ONLY = 2'h0;
  localparam logic [1:0] SEL_HYBRID   = 2'h3;

endpackage

// ==== hdl/mdc_sample_link.sv ====
`timescale 1ns/1ps
// ==========================================================================
// link-side capture of one magnetic frame per ODR end, announced by a toggle
// ==========================================================================
module mdc_sample_link
  import mdc_pkg::*;
(
  input  wire logic        link_clk,   // sensor link clock
  input  wire logic        nrst,       // async reset, active low
  input  wire logic        odr_end,    // end of one ODR cycle
  input  wire logic [15:0] samp_x,     // x sample
  input  wire logic [15:0] samp_y,     // y sample
  input  wire logic [15:0] samp_z,     // z sample
  input  wire logic        ths_evt,    // threshold event
  output logic      [47:0] held_ff,    // frozen x,y,z
  output logic             ths_ff,     // threshold seen this frame
  output logic             tog_ff      // flips once per frame
);

  logic [47:0] nxt_held;
  logic        nxt_ths;
  logic        nxt_tog;
  logic        ths_pend_ff;
  logic        nxt_ths_pend;

  // data stays frozen a whole ODR cycle, long enough for the toggle to cross
  always_comb begin
    nxt_held     = held_ff;
    nxt_ths      = ths_ff;
    nxt_tog      = tog_ff;
    nxt_ths_pend = ths_pend_ff | ths_evt;
    if (odr_end) begin
      nxt_held     = {samp_z, samp_y, samp_x};
      nxt_ths      = ths_pend_ff | ths_evt;
      nxt_tog      = ~tog_ff;
      nxt_ths_pend = 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      held_ff     <= 48'h000000000000;
      ths_ff      <= 1'b0;
      tog_ff      <= 1'b0;
      ths_pend_ff <= 1'b0;
    end else begin
      held_ff     <= nxt_held;
      ths_ff      <= nxt_ths;
      tog_ff      <= nxt_tog;
      ths_pend_ff <= nxt_ths_pend;
    end
  end

endmodule

// ==== tb/mdc_ctrl_checker.sv ====
`timescale 1ns/1ps
// ==========
// port checker
module mdc_ctrl_checker
  import mdc_pkg::*;
(
  input wire logic        SYS_CLK,         // clock
  input wire logic        NRST,            // reset, active low
  input wire logic [7:0]  REG_ADDR,        // address
  input wire logic        REG_WR,          // write strobe
  input wire logic        REG_RD,          // read strobe
  input wire logic [7:0]  REG_WDATA,       // write data
  input wire logic        FAST_READ,       // truncated burst
  input wire logic        ONESHOT_DEGAUSS, // one-shot bit
  input wire logic        ACTIVE_MODE,     // active mode
  input wire logic [7:0]  REG_RDATA,       // read data
  input wire logic [7:0]  BURST_NEXT_ADDR, // next address
  input wire logic [47:0] MAG_MAX,         // maxima
  input wire logic [47:0] MAG_MIN,         // minima
  input wire logic        DEGAUSS,         // sensor reset
  input wire logic        ONESHOT_CLEAR    // one-shot ack
);
  logic       wrap_ff;
  logic       nxt_wrap;
  logic [1:0] deg_ff;
  logic [1:0] nxt_deg;

  // shadow of the fields the assertions need, since the register is inside
  always_comb begin
    nxt_wrap = wrap_ff;
    nxt_deg = deg_ff;
    if (REG_WR && REG_ADDR == ADDR_MAG_CTRL_TWO) begin
      nxt_wrap = REG_WDATA[5];
      nxt_deg = REG_WDATA[1:0];
    end
  end

  // shadow registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wrap_ff <= 1'b0;
      deg_ff <= 2'h0;
    end else begin
      wrap_ff <= nxt_wrap;
      deg_ff <= nxt_deg;
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_wrap_slow: assert property (REG_RD && REG_ADDR == 8'h06 && !FAST_READ && wrap_ff
    |=> BURST_NEXT_ADDR == 8'h33) else $error("no wrap after 0x06");
  a_wrap_fast: assert property (REG_RD && REG_ADDR == 8'h05 && FAST_READ && wrap_ff
    |=> BURST_NEXT_ADDR == 8'h33) else $error("no wrap after 0x05");
  a_next_plain: assert property (REG_RD && !wrap_ff
    |=> BURST_NEXT_ADDR == $past(REG_ADDR) + 8'h01) else $error("bad next address");
  a_clear_load: assert property (REG_WR && REG_ADDR == 8'h5C && REG_WDATA[2]
    |-> ##2 MAG_MAX == {3{16'h8000}} && MAG_MIN == {3{16'h7FFF}}) else $error("no reload");
  a_clear_self: assert property ((REG_WR && REG_ADDR == 8'h5C && REG_WDATA[2]) ##1 !REG_WR
    ##1 (REG_RD && REG_ADDR == 8'h5C && !REG_WR) |=> !REG_RDATA[2]) else $error("clear stuck");
  a_degauss_one: assert property (DEGAUSS |=> !DEGAUSS) else $error("long degauss");
  a_oneshot_ack: assert property (ONESHOT_CLEAR |-> $past(DEGAUSS))
    else $error("ack without degauss");
  a_wake_pulse: assert property ($rose(ACTIVE_MODE) |=> DEGAUSS) else $error("no wake degauss");
  a_off_quiet: assert property (deg_ff == 2'h3 && $stable(deg_ff) && $past(ACTIVE_MODE, 2)
    && !$past(ONESHOT_DEGAUSS) |-> !DEGAUSS) else $error("periodic degauss while off");
endmodule

bind mdc_ctrl mdc_ctrl_checker i_mdc_ctrl_checker (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .FAST_READ(FAST_READ), .ONESHOT_DEGAUSS(ONESHOT_DEGAUSS), .ACTIVE_MODE(ACTIVE_MODE),
  .REG_RDATA(REG_RDATA), .BURST_NEXT_ADDR(BURST_NEXT_ADDR), .MAG_MAX(MAG_MAX),
  .MAG_MIN(MAG_MIN), .DEGAUSS(DEGAUSS), .ONESHOT_CLEAR(ONESHOT_CLEAR));

// ==== tb/mdc_link_src.sv ====
`timescale 1ns/1ps
// ==========
// sensor-side frame source, one frame per request toggle
module mdc_link_src (
  input  wire logic        link_clk, // link clock
  input  wire logic        nrst,     // reset, active low
  input  wire logic        req,      // toggle asks for a frame
  input  wire logic [47:0] frame,    // {z,y,x}
  input  wire logic        ths,      // threshold flag
  output logic             odr_end,  // end of ODR cycle
  output logic      [47:0] samp,     // {z,y,x} lines
  output logic             ths_evt   // threshold event
);
  logic seen_ff;

  // samples only mean something with odr_end, so they flip otherwise
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      seen_ff <= 1'b0;
      odr_end <= 1'b0;
      samp <= 48'h0;
      ths_evt <= 1'b0;
    end else begin
      seen_ff <= req;
      odr_end <= req != seen_ff;
      samp <= (req != seen_ff) ? frame : ~samp;
      ths_evt <= (req != seen_ff) & ths;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// ==========
// bench
module tb;
  import mdc_pkg::*;
  logic               sys_clk, link_clk, nrst, reg_wr, reg_rd, fast_read, autocal;
  logic               oneshot, active, req, ths, odr_end, ths_evt, degauss, os_clr;
  logic        [7:0]  reg_addr, reg_wdata, rdata, nxt_a, rd_d, rd_n;
  logic        [1:0]  sel;
  logic        [47:0] frame, samp, mag_max, mag_min, mag_off;
  logic signed [15:0] emax [3];
  logic signed [15:0] emin [3];
  int                 bad_count, num_checks, deg_cnt;

  // clocks, link one unrelated in phase
  initial begin sys_clk = 0; forever #10 sys_clk = ~sys_clk; end
  initial begin link_clk = 0; #7; forever #24 link_clk = ~link_clk; end
  // look just after the edge, so the pulse launched there has settled
  always @(posedge sys_clk) #1 if (degauss === 1'b1) deg_cnt++;

  mdc_ctrl i_mdc_ctrl (.SYS_CLK(sys_clk), .NRST(nrst), .LINK_CLK(link_clk),
    .LINK_ODR_END(odr_end), .LINK_SAMP_X(samp[15:0]), .LINK_SAMP_Y(samp[31:16]),
    .LINK_SAMP_Z(samp[47:32]), .LINK_THS_EVT(ths_evt), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .FAST_READ(fast_read),
    .SENSOR_SEL(sel), .AUTOCAL_EN(autocal), .ONESHOT_DEGAUSS(oneshot),
    .ACTIVE_MODE(active), .REG_RDATA(rdata), .BURST_NEXT_ADDR(nxt_a), .MAG_MAX(mag_max),
    .MAG_MIN(mag_min), .MAG_OFFSET(mag_off), .DEGAUSS(degauss), .ONESHOT_CLEAR(os_clr));
  mdc_link_src i_mdc_link_src (.link_clk(link_clk), .nrst(nrst), .req(req),
    .frame(frame), .ths(ths), .odr_end(odr_end), .samp(samp), .ths_evt(ths_evt));

  // ==========
  // helpers
  function automatic logic [47:0] pk(input logic signed [15:0] v [3]);
    return {v[2], v[1], v[0]};
  endfunction
  function automatic logic [47:0] offs();
    logic signed [16:0] s;
    for (int i = 0; i < 3; i++) begin s = emax[i] + emin[i]; offs[16*i+:16] = s[16:1]; end
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk); reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge sys_clk); reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk); reg_rd = 1; reg_addr = a;
    @(negedge sys_clk); reg_rd = 0; rd_d = rdata; rd_n = nxt_a;
  endtask
  // frames spaced well past the two link clocks and four system clocks the crossing needs
  task automatic send(input logic [47:0] f, input logic t, input logic upd);
    logic signed [15:0] s;
    @(negedge sys_clk); frame = f; ths = t; req = ~req;
    repeat (14) @(negedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      s = f[16*i+:16];
      if (upd && s > emax[i]) emax[i] = s;
      if (upd && s < emin[i]) emin[i] = s;
    end
  endtask
  task automatic clr(input logic [7:0] d);
    wr(ADDR_MAG_CTRL_TWO, d | 8'h04);
    for (int i = 0; i < 3; i++) begin emax[i] = 16'h8000; emin[i] = 16'h7FFF; end
  endtask
  task automatic wake(input logic [1:0] c);
    active = 0; wr(ADDR_MAG_CTRL_TWO, {6'h00, c}); repeat (3) @(negedge sys_clk);
    deg_cnt = 0; active = 1; repeat (4) @(negedge sys_clk);
    `CHK(deg_cnt, 1)
    deg_cnt = 0;
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic s_reset();
    `CHK({mag_max, mag_min, mag_off}, {{3{16'h8000}}, {3{16'h7FFF}}, 48'h0})
    rd(ADDR_MAG_CTRL_TWO); `CHK(rd_d, 8'h00)
  endtask
  task automatic s_regs();
    wr(ADDR_MAG_CTRL_TWO, 8'hE0); wr(8'h5D, 8'hFF); rd(8'h5D); `CHK(rd_d, 8'h00)
    rd(ADDR_MAG_CTRL_TWO); `CHK(rd_d, 8'hE0)
    fast_read = 0; rd(8'h06); `CHK(rd_n, 8'h33)
    rd(8'h05); `CHK(rd_n, 8'h06)
    fast_read = 1; rd(8'h05); `CHK(rd_n, 8'h33)
    rd(8'h06); `CHK(rd_n, 8'h07)
    fast_read = 0; wr(ADDR_MAG_CTRL_TWO, 8'h00); rd(8'h06); `CHK(rd_n, 8'h07)
  endtask
  task automatic s_track();
    logic [47:0] ft [3];
    ft = '{48'h0100_FF00_0005, 48'h8001_7FFE_0003, 48'hC000_0000_4000};
    wake(DEG_EVERY); clr(8'h00); repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      send(ft[i], 1'b0, 1'b1);
      `CHK({mag_max, mag_min}, {pk(emax), pk(emin)})
      `CHK(mag_off, offs())
    end
  endtask
  task automatic s_stop();
    wr(ADDR_MAG_CTRL_TWO, 8'h10); send({3{16'h7FFF}}, 1'b0, 1'b0);
    `CHK(mag_max, pk(emax))
    wr(ADDR_MAG_CTRL_TWO, 8'h08); send({3{16'h7000}}, 1'b1, 1'b1);
    `CHK(mag_max, pk(emax))
    send({3{16'h7FFF}}, 1'b0, 1'b0); `CHK(mag_max, pk(emax))
    // read right behind the clear so the self-clear is seen at its first chance
    clr(8'h00); rd(ADDR_MAG_CTRL_TWO); `CHK(rd_d, 8'h00)
    `CHK({mag_max, mag_min}, {{3{16'h8000}}, {3{16'h7FFF}}})
    send({3{16'h7000}}, 1'b1, 1'b1); send({3{16'h9000}}, 1'b0, 1'b1);
    `CHK({mag_max, mag_min}, {pk(emax), pk(emin)})
  endtask
  task automatic s_deg(input logic [1:0] c, input int n, input int exp_at);
    int first;
    first = 0; wake(c);
    for (int k = 1; k <= n; k++) begin
      send(48'h0, 1'b0, 1'b1);
      if (deg_cnt > 0 && first == 0) first = k;
    end
    `CHK(first, exp_at)
  endtask
  task automatic s_oneshot();
    int k;
    deg_cnt = 0; k = 0;
    @(negedge sys_clk); oneshot = 1;
    while (os_clr !== 1'b1 && k < 10) begin @(negedge sys_clk); k++; end
    oneshot = 0;
    if (k == 10) begin bad_count++; close_out(); end
    repeat (5) @(negedge sys_clk);
    `CHK(deg_cnt, 1)
  endtask
  task automatic s_hybrid();
    sel = SEL_HYBRID; wake(DEG_OFF); clr(8'h03); repeat (3) @(negedge sys_clk);
    send(48'h1111_2222_3333, 1'b0, 1'b0); `CHK(mag_max, pk(emax))
    send(48'h1111_2222_3333, 1'b0, 1'b1); `CHK(mag_max, pk(emax))
  endtask

  // ==========
  // main sequence
  initial begin
    {nrst, reg_wr, reg_rd, fast_read, autocal, oneshot, active, req, ths} = '0;
    {reg_addr, reg_wdata, sel, frame, bad_count, num_checks, deg_cnt} = '0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk); nrst = 1;
    s_reset(); s_regs();
    sel = 2'h1; autocal = 1;
    s_track(); s_stop();
    s_deg(DEG_EVERY, 2, 1);
    s_deg(DEG_16, 20, 15);
    s_deg(DEG_512, 512, 511);
    s_deg(DEG_OFF, 20, 0);
    s_oneshot(); s_hybrid();
    close_out();
  end
endmodule
